// ---- verilog/vgc_pkg.sv ----
// Package: register map, field layout and reset values of the voice gain command block
package vgc_pkg;
   // AXI4-Lite register byte offsets
   localparam logic [3:0] VGC_CMD_OFS = 4'h0;
   localparam logic [3:0] VGC_SEND_OFS = 4'h4;
   localparam logic [3:0] VGC_RECV_OFS = 4'h8;
   localparam logic [3:0] VGC_STAT_OFS = 4'hC;
   // Command decode
   localparam logic [4:0] VGC_SEND_ADDR = 5'h03;
   localparam logic [2:0] VGC_RECV_ADDR = 3'h1;
   localparam int VGC_SEND_TOP = 3;
   localparam int VGC_SEND_ZERO_BIT = 2;
   localparam int VGC_RECV_TOP = 5;
   // Field positions
   localparam int VGC_ATTEN_BIT = 0;
   localparam int VGC_AMP2_BIT = 1;
   localparam int VGC_VOL_W = 5;
   // Reset images
   localparam logic [7:0] VGC_SEND_RST = 8'h18;
   localparam logic [7:0] VGC_RECV_RST = 8'h3F;
   // AXI responses
   localparam logic [1:0] VGC_RESP_OKAY = 2'b00;
   localparam logic [1:0] VGC_RESP_SLVERR = 2'b10;
endpackage : vgc_pkg

// ---- verilog/vgc_regs.sv ----
// Module: voice gain command decoder with AXI4-Lite register access
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RL1: Command 000110xx writes send-gain register; reset image 18H.
// RL2: Send-gain bit 0 selects 0 dB or 3 dB pre-filter attenuation.
// RL3: Send-gain bit 1 powers receiver amplifier 2 up when set.
// RL4: Send-gain contents are held unchanged during power-down.
// RL5: After power returns, prior settings drive outputs again without rewrite.
// RL6: Command 001xxxxx writes low five bits to receive-volume; reset 3FH.
// RL7: Volume code maps linearly, 1 dB attenuation per step, 0 to 31.
// RL8: Host forms one byte, address high, in the bit order expected.
// RL9: Writes to both registers take effect at once, no periodic fetch.
// RL10: Writes during standby are held; effect applied when standby clears.
// RL11: Command words matching neither register address are ignored here.
module vgc_regs (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Device state
   input wire logic power_down_i,
   input wire logic standby_i,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [3:0] s_axi_awaddr_i,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   // AXI4-Lite write response
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   output logic [1:0] s_axi_bresp_o,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   input wire logic [3:0] s_axi_araddr_i,
   // AXI4-Lite read data
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   // Analog controls
   output logic prefilter_atten_select_o,
   output logic amp2_power_up_o,
   output logic [4:0] volume_code_o
);
   import vgc_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic aw_got_q, aw_got_d;
   logic w_got_q, w_got_d;
   logic [3:0] awaddr_q, awaddr_d;
   logic [7:0] wbyte_q, wbyte_d;
   logic wlane_q, wlane_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [7:0] send_q, send_d;
   logic [VGC_VOL_W-1:0] vol_q, vol_d;
   logic atten_q, atten_d;
   logic amp2_q, amp2_d;
   logic [VGC_VOL_W-1:0] vol_out_q, vol_out_d;
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic arready_q, arready_d;

   // ------------------------------------------------------------
   // Bus and register next state
   // ------------------------------------------------------------
   logic do_write;
   logic [7:0] cmd;
   always_comb begin
      aw_got_d = aw_got_q;
      w_got_d = w_got_q;
      awaddr_d = awaddr_q;
      wbyte_d = wbyte_q;
      wlane_d = wlane_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      send_d = send_q;
      vol_d = vol_q;
      cmd = wbyte_q;
      if (s_axi_awvalid_i && !aw_got_q && !bvalid_q) begin
         aw_got_d = 1'b1;
         awaddr_d = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_got_q && !bvalid_q) begin
         w_got_d = 1'b1;
         wbyte_d = s_axi_wdata_i[7:0];
         wlane_d = s_axi_wstrb_i[0];
      end
      do_write = aw_got_q && w_got_q && !bvalid_q;
      if (do_write) begin
         aw_got_d = 1'b0;
         w_got_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = VGC_RESP_OKAY;
         if (awaddr_q == VGC_CMD_OFS) begin
            if (wlane_q) begin
               // Writes land even in standby or power-down; the outputs stage decides use [RL10]
               if (cmd[7:VGC_SEND_TOP] == VGC_SEND_ADDR && !cmd[VGC_SEND_ZERO_BIT]) begin
                  send_d = cmd; // [RL1] [RL9]
               end else if (cmd[7:VGC_RECV_TOP] == VGC_RECV_ADDR) begin
                  vol_d = cmd[VGC_VOL_W-1:0]; // [RL6] [RL9]
               end
               // Other addresses belong to other decoders [RL11]
            end
         end else if (awaddr_q != VGC_SEND_OFS && awaddr_q != VGC_RECV_OFS && awaddr_q != VGC_STAT_OFS) begin
            bresp_d = VGC_RESP_SLVERR;
         end
      end else if (bvalid_q && s_axi_bready_i) begin
         bvalid_d = 1'b0;
      end
      if (rvalid_q) begin
         if (s_axi_rready_i) begin
            rvalid_d = 1'b0;
         end
      end else if (s_axi_arvalid_i) begin
         rvalid_d = 1'b1;
         rresp_d = VGC_RESP_OKAY;
         unique case (s_axi_araddr_i)
            VGC_CMD_OFS: rdata_d = 32'h0000_0000;
            VGC_SEND_OFS: rdata_d = {24'h00_0000, send_q};
            VGC_RECV_OFS: rdata_d = {27'h000_0000, vol_q};
            VGC_STAT_OFS: rdata_d = {25'h000_0000, vol_out_q, amp2_q, atten_q};
            default: begin
               rdata_d = 32'h0000_0000;
               rresp_d = VGC_RESP_SLVERR;
            end
         endcase
      end
      // Readies registered so every bus output leaves a flip-flop
      awready_d = !aw_got_d && !bvalid_d;
      wready_d = !w_got_d && !bvalid_d;
      arready_d = !rvalid_d;
   end

   // ------------------------------------------------------------
   // Applied analog controls
   // ------------------------------------------------------------
   always_comb begin
      atten_d = atten_q;
      amp2_d = amp2_q;
      vol_out_d = vol_out_q;
      // Outputs freeze in standby; stored values survive power-down untouched [RL4] [RL10]
      if (!standby_i) begin
         atten_d = send_q[VGC_ATTEN_BIT]; // [RL2]
         vol_out_d = vol_q; // [RL7]
         // Amplifier 2 off while device is down; restored from stored bit after [RL5]
         amp2_d = send_q[VGC_AMP2_BIT] && !power_down_i; // [RL3] [RL5]
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 4'h0;
         wbyte_q <= 8'h00;
         wlane_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= VGC_RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= VGC_RESP_OKAY;
         send_q <= VGC_SEND_RST; // [RL1]
         vol_q <= VGC_RECV_RST[VGC_VOL_W-1:0]; // [RL6]
         atten_q <= VGC_SEND_RST[VGC_ATTEN_BIT];
         amp2_q <= VGC_SEND_RST[VGC_AMP2_BIT];
         vol_out_q <= VGC_RECV_RST[VGC_VOL_W-1:0];
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         arready_q <= 1'b1;
      end else begin
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         awaddr_q <= awaddr_d;
         wbyte_q <= wbyte_d;
         wlane_q <= wlane_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         send_q <= send_d;
         vol_q <= vol_d;
         atten_q <= atten_d;
         amp2_q <= amp2_d;
         vol_out_q <= vol_out_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         arready_q <= arready_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign s_axi_awready_o = awready_q;
   assign s_axi_wready_o = wready_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_arready_o = arready_q;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;
   assign prefilter_atten_select_o = atten_q;
   assign amp2_power_up_o = amp2_q;
   assign volume_code_o = vol_out_q;
endmodule : vgc_regs
`default_nettype wire

// ---- bench/vgc_regs_props.sv ----
// Checker: bus timing and control output relations
`timescale 1ns/1ps
`default_nettype none
module vgc_regs_props (
   input wire logic clk_i, rst_i, power_down_i, standby_i,
   input wire logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i,
   input wire logic s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i,
   input wire logic prefilter_atten_select_o, amp2_power_up_o,
   input wire logic [4:0] volume_code_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_bl; $rose(s_axi_bvalid_o) |-> !$past(s_axi_awready_o) && !$past(s_axi_wready_o); endproperty
   a_bl: assert property (p_bl) else $error("bvalid without commit cycle");
   property p_bh; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o; endproperty
   a_bh: assert property (p_bh) else $error("bvalid dropped early");
   property p_rh; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && !s_axi_arready_o; endproperty
   a_rh: assert property (p_rh) else $error("rvalid dropped early");
   property p_pd; power_down_i && !standby_i |=> !amp2_power_up_o; endproperty
   a_pd: assert property (p_pd) else $error("amp2 up in power-down");
   property p_sb; standby_i |=> $stable(volume_code_o) && $stable(prefilter_atten_select_o); endproperty
   a_sb: assert property (p_sb) else $error("output moved in standby");
   property p_vc; $changed(volume_code_o) |-> $past(s_axi_bvalid_o) || $past(standby_i, 2); endproperty
   a_vc: assert property (p_vc) else $error("volume moved without write");
   property p_vs; $changed(volume_code_o) |-> !$past(standby_i); endproperty
   a_vs: assert property (p_vs) else $error("volume applied in standby");
   property p_au; $rose(amp2_power_up_o) |-> !$past(power_down_i) && !$past(standby_i); endproperty
   a_au: assert property (p_au) else $error("amp2 rose while held");
   c_wr: cover property (s_axi_bvalid_o && s_axi_bready_i);
   c_pd: cover property ($fell(amp2_power_up_o));
   c_sb: cover property ($fell(standby_i));
endmodule : vgc_regs_props
bind vgc_regs vgc_regs_props u_props (.*);
`default_nettype wire

// ---- bench/vgc_host_model.sv ----
// Partner: bus master model of the command-writing controller
`timescale 1ns/1ps
`default_nettype none
module vgc_host_model (
   input wire logic clk_i,
   output logic s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i,
   output logic [3:0] s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i,
   output logic [31:0] s_axi_wdata_i,
   input wire logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0] s_axi_bresp_o, s_axi_rresp_o
);
   initial {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h00;
   initial {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i, s_axi_wdata_i} = 44'h00F_0000_0000;
   task automatic write(input logic [3:0] a, input logic [7:0] c, output logic [1:0] r);
      bit aw = 0;
      bit w = 0;
      @(posedge clk_i);
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= {24'h00_0000, c};
      do begin
         @(posedge clk_i);
         aw |= s_axi_awready_o;
         w |= s_axi_wready_o;
         if (aw) s_axi_awvalid_i <= 1'b0;
         if (w) s_axi_wvalid_i <= 1'b0;
      end while (!(aw && w));
      // Inverted after release so a stale byte cannot pass
      s_axi_wdata_i <= ~s_axi_wdata_i;
      do @(posedge clk_i); while (!s_axi_bvalid_o);
      r = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
   endtask : write
   task automatic read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
      s_axi_araddr_i <= a;
      do @(posedge clk_i); while (!s_axi_arready_o);
      s_axi_arvalid_i <= 1'b0;
      do @(posedge clk_i); while (!s_axi_rvalid_o);
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      s_axi_rready_i <= 1'b0;
   endtask : read
endmodule : vgc_host_model
`default_nettype wire

// ---- bench/vgc_regs_bench.sv ----
// Bench: self-checking test of the voice gain command block
`timescale 1ns/1ps
`default_nettype none
module vgc_regs_bench;
   import vgc_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, power_down_i = 1'b0, standby_i = 1'b0;
   logic s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic [3:0] s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   logic prefilter_atten_select_o, amp2_power_up_o;
   logic [4:0] volume_code_o;
   int n_fail = 0, cmp_count = 0, cyc = 0;
   vgc_regs dut (.*);
   vgc_host_model host (.*);
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] c, input logic [3:0] a = VGC_CMD_OFS, input logic [1:0] e = VGC_RESP_OKAY);
      logic [1:0] r;
      host.write(a, c, r);
      chk("bresp", 32'(e), 32'(r));
      @(negedge clk_i);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] e = VGC_RESP_OKAY);
      logic [31:0] d;
      logic [1:0] r;
      host.read(a, d, r);
      chk("rdata", ed, d);
      chk("rresp", 32'(e), 32'(r));
   endtask : rd
   task automatic outs(input logic [6:0] e);
      chk("outputs", 32'(e), 32'({prefilter_atten_select_o, amp2_power_up_o, volume_code_o}));
   endtask : outs
   task automatic t_reset();
      outs(7'h1F);
      rd(VGC_SEND_OFS, 32'h0000_0018);
      rd(4'h2, 32'h0000_0000, VGC_RESP_SLVERR);
   endtask : t_reset
   task automatic t_send();
      for (int k = 0; k < 4; k++) begin
         wr(8'h18 + 8'(k));
         outs({k[0], k[1], 5'h1F});
      end
      rd(VGC_SEND_OFS, 32'h0000_001B);
   endtask : t_send
   task automatic t_vol();
      for (int k = 0; k < 32; k++) begin
         wr(8'h20 + 8'(k));
         outs({2'h3, 5'(k)});
      end
   endtask : t_vol
   task automatic t_ignore();
      wr(8'h1C);
      wr(8'h47);
      wr(8'h00, 4'h2, VGC_RESP_SLVERR);
      outs(7'h7F);
   endtask : t_ignore
   task automatic t_pdown();
      power_down_i <= 1'b1;
      repeat (2) @(negedge clk_i);
      outs(7'h5F);
      rd(VGC_SEND_OFS, 32'h0000_001B);
      power_down_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      outs(7'h7F);
   endtask : t_pdown
   task automatic t_standby();
      standby_i <= 1'b1;
      wr(8'h25);
      wr(8'h18);
      outs(7'h7F);
      rd(VGC_RECV_OFS, 32'h0000_0005);
      standby_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      outs(7'h05);
      rd(VGC_STAT_OFS, 32'h0000_0014);
   endtask : t_standby
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      t_reset();
      t_send();
      t_vol();
      t_ignore();
      @(posedge clk_i);
      t_pdown();
      @(posedge clk_i);
      t_standby();
      give_verdict();
   end
endmodule : vgc_regs_bench
`default_nettype wire
